// ==== verilog/asmu_core.sv ====
// Shift and immediate-mask data-path slice with AHB-Lite register access
// Function
// - Register mask AND: 4 cycles, 2 words, no stack
// - Memory mask AND cycle and word counts per mode
// - Peripheral short address mask AND: 4 cycles
// - Left shift: old MSB to carry, zero in
// - Left shift on 16-bit register is logical
// - Left shift: V on bit 35 change, C old
// - Accumulator left shift sets L, E, N, Z flags
// - Accumulator left shift: 2 cycles, one word
// - Shift with parallel move fits one word
// - Multi-bit left shift by low four bits
// - Accumulator: shift upper, clear lower, sign-extend
// - Multi-bit shift ignores saturation bit
// - Multi-bit shift: six pairs, 2 cycles, N Z
// - Right shift: old LSB to carry, MSB kept
// - Mask AND is clear with inverted immediate
// - Carry set when all masked bits set
// - Mask AND reads then writes destination
`timescale 1ns/1ps
module asmu_core #(
	parameter int MEM_AW = 7
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata
);
	asmu_pkg::asmu_state_t s;
	asmu_pkg::asmu_state_t nx;
	logic mem_we;
	logic [MEM_AW-1:0] mem_addr;
	logic [15:0] mem_wdata;
	logic [15:0] mem_rdata;

	asmu_xmem #(.AW(MEM_AW), .DW(16)) u_xmem (
		.clk(clk),
		.rst_b(rst_b),
		.write_en(mem_we),
		.addr(mem_addr),
		.write_data(mem_wdata),
		.read_data(mem_rdata)
	);

	function automatic logic [15:0] get16(asmu_pkg::asmu_state_t st, logic [2:0] code);
		logic [15:0] v;
		v = '0;
		unique case (code)
			asmu_pkg::REG_X0: v = st.x0;
			asmu_pkg::REG_Y0: v = st.y0;
			asmu_pkg::REG_Y1: v = st.y1;
			asmu_pkg::REG_A: v = st.a[31:16];
			asmu_pkg::REG_B: v = st.b[31:16];
			asmu_pkg::REG_R: v = st.r;
			asmu_pkg::REG_N: v = st.n;
			asmu_pkg::REG_HWS: v = '0;
		endcase
		return v;
	endfunction

	function automatic asmu_pkg::asmu_state_t put16(asmu_pkg::asmu_state_t st,
		logic [2:0] code, logic [15:0] v);
		asmu_pkg::asmu_state_t o;
		o = st;
		unique case (code)
			asmu_pkg::REG_X0: o.x0 = v;
			asmu_pkg::REG_Y0: o.y0 = v;
			asmu_pkg::REG_Y1: o.y1 = v;
			asmu_pkg::REG_A: o.a[31:16] = v;
			asmu_pkg::REG_B: o.b[31:16] = v;
			asmu_pkg::REG_R: o.r = v;
			asmu_pkg::REG_N: o.n = v;
			asmu_pkg::REG_HWS: o.n = st.n;
		endcase
		return o;
	endfunction

	// Accumulator flags; U and E follow the core-wide definitions
	function automatic logic [7:0] acc_flags(logic [7:0] c, logic [35:0] r);
		logic [7:0] o;
		o = c;
		o[asmu_pkg::CCR_E] = !((&r[35:31]) || !(|r[35:31]));
		o[asmu_pkg::CCR_U] = !(r[31] ^ r[30]);
		o[asmu_pkg::CCR_N] = r[35];
		o[asmu_pkg::CCR_Z] = (r == '0);
		return o;
	endfunction

	function automatic logic [31:0] rd_reg(asmu_pkg::asmu_state_t st, logic [11:0] ad);
		logic [31:0] v;
		v = '0;
		case (ad)
			asmu_pkg::ADDR_CMD: v = {16'h0000, st.cmd};
			asmu_pkg::ADDR_OPERAND: v = st.operand;
			asmu_pkg::ADDR_STATUS: v = {26'h0, st.words, 2'h0, st.err, st.est == asmu_pkg::ASMU_E_RUN};
			asmu_pkg::ADDR_CCR: v = {24'h0, st.condition_code_reg};
			asmu_pkg::ADDR_MODE: v = {24'h0, st.mode};
			asmu_pkg::ADDR_X0: v = {16'h0000, st.x0};
			asmu_pkg::ADDR_Y0: v = {16'h0000, st.y0};
			asmu_pkg::ADDR_Y1: v = {16'h0000, st.y1};
			asmu_pkg::ADDR_A_LO: v = st.a[31:0];
			asmu_pkg::ADDR_A_HI: v = {28'h0, st.a[35:32]};
			asmu_pkg::ADDR_B_LO: v = st.b[31:0];
			asmu_pkg::ADDR_B_HI: v = {28'h0, st.b[35:32]};
			asmu_pkg::ADDR_R: v = {16'h0000, st.r};
			asmu_pkg::ADDR_N: v = {16'h0000, st.n};
			asmu_pkg::ADDR_SP: v = {16'h0000, st.sp};
			default: v = '0;
		endcase
		return v;
	endfunction

	logic [3:0] op;
	logic [2:0] dst;
	logic [2:0] pair;
	logic pm_en;
	logic pm_wr;
	logic [2:0] pm_reg;
	logic is_acc;
	logic is_mem_and_immediate_mask;
	logic [MEM_AW-1:0] ea;
	logic [15:0] imm;
	logic [15:0] d16;
	logic [15:0] res16;
	logic [15:0] s1;
	logic [15:0] s2;
	logic [35:0] acc;
	logic [35:0] racc;
	logic [15:0] pm_val;
	logic lim;
	logic bus_mem;
	logic [15:0] ncmd;
	logic legal;

	always_comb
	begin
		nx = s;
		mem_we = 1'b0;
		mem_addr = '0;
		mem_wdata = '0;
		op = s.cmd[asmu_pkg::CMD_OP_LSB +: 4];
		dst = s.cmd[asmu_pkg::CMD_DST_LSB +: 3];
		pair = s.cmd[asmu_pkg::CMD_PAIR_LSB +: 3];
		pm_en = s.cmd[asmu_pkg::CMD_PM_EN];
		pm_wr = s.cmd[asmu_pkg::CMD_PM_WR];
		pm_reg = s.cmd[asmu_pkg::CMD_PM_REG_LSB +: 3];
		imm = s.operand[15:0];
		is_acc = (dst == asmu_pkg::REG_A) || (dst == asmu_pkg::REG_B);
		is_mem_and_immediate_mask = (op >= asmu_pkg::OP_AND_IMMEDIATE_MASK_SHORT) && (op <= asmu_pkg::OP_AND_IMMEDIATE_MASK_ABS);
		acc = (dst == asmu_pkg::REG_A) ? s.a : s.b;
		d16 = get16(s, dst);
		racc = '0;
		res16 = '0;
		lim = 1'b0;
		pm_val = '0;
		s1 = '0;
		s2 = '0;
		ncmd = hwdata[15:0];
		legal = 1'b0;
		bus_mem = (s.baddr >= asmu_pkg::ADDR_MEM_LO) && (s.baddr <= asmu_pkg::ADDR_MEM_HI);
		unique case (op)
			asmu_pkg::OP_AND_IMMEDIATE_MASK_PERIPH: ea = MEM_AW'(asmu_pkg::PERIPH_BASE) | MEM_AW'(s.operand[21:16]);
			asmu_pkg::OP_AND_IMMEDIATE_MASK_INDEX: ea = MEM_AW'(s.r + s.operand[31:16]);
			asmu_pkg::OP_AND_IMMEDIATE_MASK_STACK: ea = MEM_AW'(s.sp - s.operand[31:16]);
			asmu_pkg::OP_AND_IMMEDIATE_MASK_ABS: ea = MEM_AW'(s.operand[31:16]);
			default: ea = MEM_AW'(s.operand[21:16]);
		endcase
		unique case (pair)
			3'h0: begin s1 = s.y1; s2 = s.x0; end
			3'h1: begin s1 = s.y0; s2 = s.x0; end
			3'h2: begin s1 = s.y1; s2 = s.y0; end
			3'h3: begin s1 = s.y0; s2 = s.y0; end
			3'h4: begin s1 = s.a[31:16]; s2 = s.y0; end
			default: begin s1 = s.b[31:16]; s2 = s.y1; end
		endcase

		// Execution: memory is addressed for the whole run, work commits on the last cycle
		if (s.est == asmu_pkg::ASMU_E_RUN)
		begin
			mem_addr = is_mem_and_immediate_mask ? ea : MEM_AW'(s.r);
			nx.cnt = s.cnt - 4'h1;
			if (s.cnt == 4'h0)
			begin
				nx.est = asmu_pkg::ASMU_E_IDLE;
				if (pm_en)
				begin
					if (pm_wr)
					begin
						unique case (pm_reg)
							asmu_pkg::REG_A, asmu_pkg::REG_B:
							begin
								racc = (pm_reg == asmu_pkg::REG_A) ? s.a : s.b;
								// Limited transfer saturates instead of wrapping
								lim = !((&racc[35:31]) || !(|racc[35:31]));
								pm_val = lim ? (racc[35] ? 16'h8000 : 16'h7FFF) : racc[31:16];
								nx.condition_code_reg[asmu_pkg::CCR_SZ] = s.condition_code_reg[asmu_pkg::CCR_SZ] | (racc[30] ^ racc[29]);
							end
							asmu_pkg::PM_A1: pm_val = s.a[31:16];
							asmu_pkg::PM_B1: pm_val = s.b[31:16];
							default: pm_val = get16(s, pm_reg);
						endcase
						mem_we = 1'b1;
						mem_wdata = pm_val;
					end
					else
					begin
						// ALU result written after this, so it wins a duplicate destination
						unique case (pm_reg)
							asmu_pkg::REG_A: nx.a = {{4{mem_rdata[15]}}, mem_rdata, 16'h0000};
							asmu_pkg::REG_B: nx.b = {{4{mem_rdata[15]}}, mem_rdata, 16'h0000};
							asmu_pkg::PM_A1: nx.a[31:16] = mem_rdata;
							asmu_pkg::PM_B1: nx.b[31:16] = mem_rdata;
							default: nx = put16(nx, pm_reg, mem_rdata);
						endcase
					end
					nx.r = s.r + (s.cmd[asmu_pkg::CMD_PM_N] ? s.n : 16'h0001);
				end
				unique case (op)
					asmu_pkg::OP_AND_IMMEDIATE_MASK_REG:
					begin
						nx = put16(nx, dst, d16 & imm);
						nx.condition_code_reg[asmu_pkg::CCR_C] = ((d16 & ~imm) == ~imm);
					end
					asmu_pkg::OP_SHL1:
					begin
						if (is_acc)
						begin
							racc = {acc[34:0], 1'b0};
							// Built on nx so the size flag of a parallel write survives
							nx.condition_code_reg = acc_flags(nx.condition_code_reg, racc);
							nx.condition_code_reg[asmu_pkg::CCR_C] = acc[35];
							nx.condition_code_reg[asmu_pkg::CCR_V] = acc[35] ^ acc[34];
							nx.condition_code_reg[asmu_pkg::CCR_L] = s.condition_code_reg[asmu_pkg::CCR_L] | lim | (acc[35] ^ acc[34]);
							if (dst == asmu_pkg::REG_A)
							begin
								nx.a = racc;
							end
							else
							begin
								nx.b = racc;
							end
						end
						else
						begin
							res16 = {d16[14:0], 1'b0};
							nx = put16(nx, dst, res16);
							nx.condition_code_reg[asmu_pkg::CCR_C] = d16[15];
							nx.condition_code_reg[asmu_pkg::CCR_V] = 1'b0;
							nx.condition_code_reg[asmu_pkg::CCR_N] = res16[15];
							nx.condition_code_reg[asmu_pkg::CCR_Z] = (res16 == '0);
						end
					end
					asmu_pkg::OP_SHR1:
					begin
						if (is_acc)
						begin
							racc = {acc[35], acc[35:1]};
							nx.condition_code_reg = acc_flags(nx.condition_code_reg, racc);
							nx.condition_code_reg[asmu_pkg::CCR_C] = acc[0];
							nx.condition_code_reg[asmu_pkg::CCR_V] = 1'b0;
							nx.condition_code_reg[asmu_pkg::CCR_L] = s.condition_code_reg[asmu_pkg::CCR_L] | lim;
							if (dst == asmu_pkg::REG_A)
							begin
								nx.a = racc;
							end
							else
							begin
								nx.b = racc;
							end
						end
						else
						begin
							res16 = {d16[15], d16[15:1]};
							nx = put16(nx, dst, res16);
							nx.condition_code_reg[asmu_pkg::CCR_C] = d16[0];
							nx.condition_code_reg[asmu_pkg::CCR_V] = 1'b0;
							nx.condition_code_reg[asmu_pkg::CCR_N] = res16[15];
							nx.condition_code_reg[asmu_pkg::CCR_Z] = (res16 == '0);
						end
					end
					asmu_pkg::OP_SHLM:
					begin
						// Mode register never consulted: no clamping on this path
						res16 = s1 << s2[3:0];
						nx.condition_code_reg[asmu_pkg::CCR_N] = res16[15];
						nx.condition_code_reg[asmu_pkg::CCR_Z] = (res16 == '0);
						if (dst == asmu_pkg::REG_A)
						begin
							nx.a = {{4{res16[15]}}, res16, 16'h0000};
						end
						else if (dst == asmu_pkg::REG_B)
						begin
							nx.b = {{4{res16[15]}}, res16, 16'h0000};
						end
						else
						begin
							nx = put16(nx, dst, res16);
						end
					end
					default:
					begin
						if (is_mem_and_immediate_mask)
						begin
							// Second destination access of the read-modify-write
							mem_we = 1'b1;
							mem_wdata = mem_rdata & imm;
							nx.condition_code_reg[asmu_pkg::CCR_C] = ((mem_rdata & ~imm) == ~imm);
						end
					end
				endcase
			end
		end

		// AHB-Lite slave: one wait state for registers, two for memory reads
		nx.hresp = 1'b0;
		unique case (s.bst)
			asmu_pkg::ASMU_B_IDLE:
			begin
				if (hsel && htrans[1] && hready)
				begin
					nx.bst = asmu_pkg::ASMU_B_DATA;
					nx.baddr = haddr[11:0];
					nx.bwrite = hwrite;
					nx.hready = 1'b0;
				end
			end
			asmu_pkg::ASMU_B_DATA:
			begin
				// Writes and memory reads wait while an instruction runs
				if (!(s.est == asmu_pkg::ASMU_E_RUN && (s.bwrite || bus_mem)))
				begin
					if (bus_mem && !s.bwrite)
					begin
						mem_addr = MEM_AW'((s.baddr - asmu_pkg::ADDR_MEM_LO) >> 2);
						nx.bst = asmu_pkg::ASMU_B_MRD;
					end
					else
					begin
						nx.bst = asmu_pkg::ASMU_B_IDLE;
						nx.hready = 1'b1;
						nx.hrdata = s.bwrite ? s.hrdata : rd_reg(s, s.baddr);
						if (s.bwrite && bus_mem)
						begin
							mem_we = 1'b1;
							mem_addr = MEM_AW'((s.baddr - asmu_pkg::ADDR_MEM_LO) >> 2);
							mem_wdata = hwdata[15:0];
						end
						else if (s.bwrite)
						begin
							unique case (s.baddr)
								asmu_pkg::ADDR_CMD:
								begin
									nx.cmd = ncmd;
									unique case (ncmd[3:0])
										asmu_pkg::OP_AND_IMMEDIATE_MASK_REG:
										begin
											nx.cnt = asmu_pkg::CYC_AND_IMMEDIATE_MASK_SHORT - 4'h1;
											nx.words = asmu_pkg::WORDS_AND_IMMEDIATE_MASK;
											legal = (ncmd[6:4] != asmu_pkg::REG_HWS) && !ncmd[10];
										end
										asmu_pkg::OP_AND_IMMEDIATE_MASK_SHORT, asmu_pkg::OP_AND_IMMEDIATE_MASK_PERIPH:
										begin
											nx.cnt = asmu_pkg::CYC_AND_IMMEDIATE_MASK_SHORT - 4'h1;
											nx.words = asmu_pkg::WORDS_AND_IMMEDIATE_MASK;
											legal = !ncmd[10];
										end
										asmu_pkg::OP_AND_IMMEDIATE_MASK_INDEX, asmu_pkg::OP_AND_IMMEDIATE_MASK_STACK, asmu_pkg::OP_AND_IMMEDIATE_MASK_ABS:
										begin
											nx.cnt = asmu_pkg::CYC_AND_IMMEDIATE_MASK_LONG - 4'h1;
											nx.words = (ncmd[3:0] == asmu_pkg::OP_AND_IMMEDIATE_MASK_ABS) ?
												asmu_pkg::WORDS_AND_IMMEDIATE_MASK_ABS : asmu_pkg::WORDS_AND_IMMEDIATE_MASK;
											legal = !ncmd[10];
										end
										asmu_pkg::OP_SHL1, asmu_pkg::OP_SHR1, asmu_pkg::OP_SHLM:
										begin
											nx.cnt = asmu_pkg::CYC_SHIFT - 4'h1;
											nx.words = asmu_pkg::WORDS_SHIFT;
											legal = (ncmd[6:4] <= asmu_pkg::REG_B) &&
												(!ncmd[10] || ((ncmd[6:4] >= asmu_pkg::REG_A) &&
												ncmd[15:13] <= asmu_pkg::PM_B1 && ncmd[3:0] != asmu_pkg::OP_SHLM)) &&
												(ncmd[3:0] != asmu_pkg::OP_SHLM || ncmd[9:7] <= asmu_pkg::PAIR_LAST);
										end
										default: legal = 1'b0;
									endcase
									nx.err = !legal;
									nx.est = legal ? asmu_pkg::ASMU_E_RUN : asmu_pkg::ASMU_E_IDLE;
								end
								asmu_pkg::ADDR_OPERAND: nx.operand = hwdata;
								asmu_pkg::ADDR_CCR: nx.condition_code_reg = hwdata[7:0];
								asmu_pkg::ADDR_MODE: nx.mode = hwdata[7:0];
								asmu_pkg::ADDR_X0: nx.x0 = hwdata[15:0];
								asmu_pkg::ADDR_Y0: nx.y0 = hwdata[15:0];
								asmu_pkg::ADDR_Y1: nx.y1 = hwdata[15:0];
								asmu_pkg::ADDR_A_LO: nx.a[31:0] = hwdata;
								asmu_pkg::ADDR_A_HI: nx.a[35:32] = hwdata[3:0];
								asmu_pkg::ADDR_B_LO: nx.b[31:0] = hwdata;
								asmu_pkg::ADDR_B_HI: nx.b[35:32] = hwdata[3:0];
								asmu_pkg::ADDR_R: nx.r = hwdata[15:0];
								asmu_pkg::ADDR_N: nx.n = hwdata[15:0];
								asmu_pkg::ADDR_SP: nx.sp = hwdata[15:0];
								default: nx.cmd = s.cmd;
							endcase
						end
					end
				end
			end
			asmu_pkg::ASMU_B_MRD:
			begin
				nx.bst = asmu_pkg::ASMU_B_IDLE;
				nx.hready = 1'b1;
				nx.hrdata = {16'h0000, mem_rdata};
			end
			default: nx.bst = asmu_pkg::ASMU_B_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s <= '0;
			s.hready <= 1'b1;
			s.condition_code_reg <= asmu_pkg::CCR_RESET;
			s.mode <= asmu_pkg::MODE_RESET;
		end
		else
		begin
			s <= nx;
		end
	end

	assign hreadyout = s.hready;
	assign hresp = s.hresp;
	assign hrdata = s.hrdata;
endmodule

// ==== shared/asmu_pkg.sv ====
// Shared constants and types for the arithmetic shift and mask unit
package asmu_pkg;
	// Register byte addresses on the AHB-Lite slave
	localparam logic [11:0] ADDR_CMD = 12'h000;
	localparam logic [11:0] ADDR_OPERAND = 12'h004;
	localparam logic [11:0] ADDR_STATUS = 12'h008;
	localparam logic [11:0] ADDR_CCR = 12'h00C;
	localparam logic [11:0] ADDR_MODE = 12'h010;
	localparam logic [11:0] ADDR_X0 = 12'h020;
	localparam logic [11:0] ADDR_Y0 = 12'h024;
	localparam logic [11:0] ADDR_Y1 = 12'h028;
	localparam logic [11:0] ADDR_A_LO = 12'h02C;
	localparam logic [11:0] ADDR_A_HI = 12'h030;
	localparam logic [11:0] ADDR_B_LO = 12'h034;
	localparam logic [11:0] ADDR_B_HI = 12'h038;
	localparam logic [11:0] ADDR_R = 12'h03C;
	localparam logic [11:0] ADDR_N = 12'h040;
	localparam logic [11:0] ADDR_SP = 12'h044;
	localparam logic [11:0] ADDR_MEM_LO = 12'h100;
	localparam logic [11:0] ADDR_MEM_HI = 12'h2FC;

	// Operation codes in the command register
	localparam logic [3:0] OP_AND_IMMEDIATE_MASK_REG = 4'h1;
	localparam logic [3:0] OP_AND_IMMEDIATE_MASK_SHORT = 4'h2;
	localparam logic [3:0] OP_AND_IMMEDIATE_MASK_PERIPH = 4'h3;
	localparam logic [3:0] OP_AND_IMMEDIATE_MASK_INDEX = 4'h4;
	localparam logic [3:0] OP_AND_IMMEDIATE_MASK_STACK = 4'h5;
	localparam logic [3:0] OP_AND_IMMEDIATE_MASK_ABS = 4'h6;
	localparam logic [3:0] OP_SHL1 = 4'h7;
	localparam logic [3:0] OP_SHR1 = 4'h8;
	localparam logic [3:0] OP_SHLM = 4'h9;

	// Command register field positions
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_DST_LSB = 4;
	localparam int CMD_PAIR_LSB = 7;
	localparam int CMD_PM_EN = 10;
	localparam int CMD_PM_WR = 11;
	localparam int CMD_PM_N = 12;
	localparam int CMD_PM_REG_LSB = 13;

	// Register selector codes (dst field)
	localparam logic [2:0] REG_X0 = 3'h0;
	localparam logic [2:0] REG_Y0 = 3'h1;
	localparam logic [2:0] REG_Y1 = 3'h2;
	localparam logic [2:0] REG_A = 3'h3;
	localparam logic [2:0] REG_B = 3'h4;
	localparam logic [2:0] REG_R = 3'h5;
	localparam logic [2:0] REG_N = 3'h6;
	localparam logic [2:0] REG_HWS = 3'h7;
	localparam logic [2:0] PM_A1 = 3'h5;
	localparam logic [2:0] PM_B1 = 3'h6;
	localparam logic [2:0] PAIR_LAST = 3'h5;

	// Condition code bit positions
	localparam int CCR_C = 0;
	localparam int CCR_V = 1;
	localparam int CCR_Z = 2;
	localparam int CCR_N = 3;
	localparam int CCR_U = 4;
	localparam int CCR_E = 5;
	localparam int CCR_L = 6;
	localparam int CCR_SZ = 7;

	localparam logic [7:0] CCR_RESET = 8'h00;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [6:0] PERIPH_BASE = 7'h40;

	// Oscillator cycles and program words per instruction form
	localparam logic [3:0] CYC_AND_IMMEDIATE_MASK_SHORT = 4'h4;
	localparam logic [3:0] CYC_AND_IMMEDIATE_MASK_LONG = 4'h6;
	localparam logic [3:0] CYC_SHIFT = 4'h2;
	localparam logic [1:0] WORDS_AND_IMMEDIATE_MASK = 2'h2;
	localparam logic [1:0] WORDS_AND_IMMEDIATE_MASK_ABS = 2'h3;
	localparam logic [1:0] WORDS_SHIFT = 2'h1;

	typedef enum logic [1:0] {ASMU_B_IDLE, ASMU_B_DATA, ASMU_B_MRD} asmu_bus_state_t;
	typedef enum logic {ASMU_E_IDLE, ASMU_E_RUN} asmu_exec_state_t;

	typedef struct packed {
		asmu_bus_state_t bst;
		logic [11:0] baddr;
		logic bwrite;
		logic hready;
		logic hresp;
		logic [31:0] hrdata;
		asmu_exec_state_t est;
		logic [3:0] cnt;
		logic [15:0] cmd;
		logic [31:0] operand;
		logic err;
		logic [1:0] words;
		logic [7:0] condition_code_reg;
		logic [7:0] mode;
		logic [15:0] x0;
		logic [15:0] y0;
		logic [15:0] y1;
		logic [15:0] r;
		logic [15:0] n;
		logic [15:0] sp;
		logic [35:0] a;
		logic [35:0] b;
	} asmu_state_t;
endpackage

// ==== verilog/asmu_xmem.sv ====
// Small X data memory with registered read data
`timescale 1ns/1ps
module asmu_xmem #(
	parameter int AW = 7,
	parameter int DW = 16
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic write_en,
	input wire logic [AW-1:0] addr,
	input wire logic [DW-1:0] write_data,
	output logic [DW-1:0] read_data
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge clk)
	begin
		if (write_en)
		begin
			mem[addr] <= write_data;
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			read_data <= '0;
		end
		else
		begin
			read_data <= mem[addr];
		end
	end
endmodule

// ==== test/asmu_core_asserts.sv ====
// Port-level bus and register-width checks for asmu_core
`timescale 1ns/1ps
module asmu_core_asserts (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	logic ph;
	logic ph_wr;
	logic [11:0] ph_a;
	logic take;
	logic rdn;
	assign take = hsel && htrans[1] && hready;
	// Read data phase ending in this cycle
	assign rdn = ph && hreadyout && !ph_wr;
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			ph <= 1'b0;
		else if (take)
			ph <= 1'b1;
		else if (hreadyout)
			ph <= 1'b0;
	end
	always_ff @(posedge clk)
	begin
		if (take)
		begin
			ph_wr <= hwrite;
			ph_a <= haddr[11:0];
		end
	end
	property p_wait;
		take |=> !hreadyout;
	endproperty
	a_wait: assert property (p_wait)
		else $error("no wait state after address phase");
	property p_bound;
		take |-> ##[2:10] hreadyout;
	endproperty
	a_bound: assert property (p_bound)
		else $error("transfer not answered in time");
	property p_mread;
		take && !hwrite && haddr[11:0] >= asmu_pkg::ADDR_MEM_LO |=> !hreadyout ##1 !hreadyout;
	endproperty
	a_mread: assert property (p_mread)
		else $error("memory read ended too early");
	property p_hold;
		!rdn |-> $stable(hrdata);
	endproperty
	a_hold: assert property (p_hold)
		else $error("read data changed outside a read");
	property p_ccr;
		rdn && ph_a == asmu_pkg::ADDR_CCR |-> hrdata[31:8] == 24'h0;
	endproperty
	a_ccr: assert property (p_ccr)
		else $error("flag register wider than 8 bits");
	property p_acc;
		rdn && (ph_a == asmu_pkg::ADDR_A_HI || ph_a == asmu_pkg::ADDR_B_HI)
			|-> hrdata[31:4] == 28'h0;
	endproperty
	a_acc: assert property (p_acc)
		else $error("accumulator extension wider than 4 bits");
	property p_mem;
		rdn && ph_a >= asmu_pkg::ADDR_MEM_LO |-> hrdata[31:16] == 16'h0;
	endproperty
	a_mem: assert property (p_mem)
		else $error("memory word wider than 16 bits");
	property p_unm;
		rdn && ph_a inside {[12'h048:12'h0FC]} |-> hrdata == 32'h0;
	endproperty
	a_unm: assert property (p_unm)
		else $error("unmapped read not zero");
	property p_okay;
		hresp == 1'b0;
	endproperty
	a_okay: assert property (p_okay)
		else $error("error response on the bus");
	c_wr: cover property (take && hwrite);
	c_ccr: cover property (rdn && ph_a == asmu_pkg::ADDR_CCR);
	c_mem: cover property (rdn && ph_a >= asmu_pkg::ADDR_MEM_LO);
endmodule
bind asmu_core asmu_core_asserts u_chk (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

// ==== test/test_arithmetic_shift_and_mask_unit.sv ====
// Self-checking bench for the shift and mask unit over AHB-Lite
`timescale 1ns/1ps
module test_arithmetic_shift_and_mask_unit;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic [31:0] q;
	logic [31:0] st;
	int error_cnt = 0;
	int num_checks = 0;
	int cyc = 0;
	asmu_core DUT (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
	initial forever #2.5 clk = ~clk;
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			error_cnt++;
			test_done();
		end
	end
	task test_done;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Waits for the slave; only the cycle ceiling ends a stuck wait
	task wt;
		do
		begin
			@(posedge clk);
		end
		while (hreadyout !== 1'b1);
	endtask
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {20'h0, a};
		hwrite <= w;
		wt();
		htrans <= 2'h0;
		hwdata <= d;
		wt();
		q = hrdata;
	endtask
	function automatic logic [11:0] ma(input int w);
		return asmu_pkg::ADDR_MEM_LO + 12'(w * 4);
	endfunction
	task run(input logic [31:0] cmd);
		int k;
		xfer(1'b1, asmu_pkg::ADDR_CMD, cmd);
		xfer(1'b0, asmu_pkg::ADDR_STATUS, 32'h0);
		st = q;
		k = 0;
		while (q[0] !== 1'b0 && k < 10)
		begin
			xfer(1'b0, asmu_pkg::ADDR_STATUS, 32'h0);
			k++;
		end
	endtask
	task rc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(q & m, e);
	endtask
	task t_regs;
		rc(asmu_pkg::ADDR_CCR, 32'hFFFFFFFF, 32'(asmu_pkg::CCR_RESET));
		rc(asmu_pkg::ADDR_MODE, 32'hFFFFFFFF, 32'(asmu_pkg::MODE_RESET));
		xfer(1'b1, 12'h080, 32'h12345678);
		rc(12'h080, 32'hFFFFFFFF, 32'h0);
		xfer(1'b1, asmu_pkg::ADDR_MODE, 32'h000000A5);
		rc(asmu_pkg::ADDR_MODE, 32'hFFFFFFFF, 32'h000000A5);
		xfer(1'b1, asmu_pkg::ADDR_STATUS, 32'hFFFFFFFF);
		rc(asmu_pkg::ADDR_STATUS, 32'hFFFFFFFF, 32'h0);
		$display("register test done");
	endtask
	task t_asl;
		xfer(1'b1, asmu_pkg::ADDR_CCR, 32'h0);
		xfer(1'b1, asmu_pkg::ADDR_A_HI, 32'hA);
		xfer(1'b1, asmu_pkg::ADDR_A_LO, 32'h01230123);
		xfer(1'b1, asmu_pkg::ADDR_R, 32'h10);
		// Old A goes out with the shift; extension in use so it is limited
		run(32'h6C37);
		chk(st & 32'h31, 32'h10);
		rc(asmu_pkg::ADDR_A_HI, 32'hFFFFFFFF, 32'h4);
		rc(asmu_pkg::ADDR_A_LO, 32'hFFFFFFFF, 32'h02460246);
		rc(asmu_pkg::ADDR_CCR, 32'hFF, 32'h73);
		rc(ma(16), 32'hFFFFFFFF, 32'h8000);
		rc(asmu_pkg::ADDR_R, 32'hFFFFFFFF, 32'h11);
		xfer(1'b1, asmu_pkg::ADDR_CCR, 32'h0);
		xfer(1'b1, asmu_pkg::ADDR_X0, 32'h8001);
		run(32'h07);
		rc(asmu_pkg::ADDR_X0, 32'hFFFFFFFF, 32'h0002);
		rc(asmu_pkg::ADDR_CCR, 32'hFF, 32'h01);
		xfer(1'b1, asmu_pkg::ADDR_X0, 32'h8000);
		run(32'h07);
		rc(asmu_pkg::ADDR_CCR, 32'hFF, 32'h05);
		$display("left shift test done");
	endtask
	task t_asr;
		xfer(1'b1, asmu_pkg::ADDR_CCR, 32'h0);
		xfer(1'b1, asmu_pkg::ADDR_B_HI, 32'hA);
		xfer(1'b1, asmu_pkg::ADDR_B_LO, 32'hA864A865);
		xfer(1'b1, asmu_pkg::ADDR_R, 32'h3);
		xfer(1'b1, ma(3), 32'h1234);
		run(32'h2448);
		rc(asmu_pkg::ADDR_B_HI, 32'hFFFFFFFF, 32'hD);
		rc(asmu_pkg::ADDR_B_LO, 32'hFFFFFFFF, 32'h54325432);
		rc(asmu_pkg::ADDR_CCR, 32'h0B, 32'h09);
		rc(asmu_pkg::ADDR_Y0, 32'hFFFFFFFF, 32'h1234);
		rc(asmu_pkg::ADDR_R, 32'hFFFFFFFF, 32'h4);
		// Upper-word read with post-increment by the offset register
		xfer(1'b1, asmu_pkg::ADDR_N, 32'h5);
		xfer(1'b1, ma(4), 32'h0777);
		run(32'hB448);
		rc(asmu_pkg::ADDR_B_LO, 32'hFFFFFFFF, 32'hAA192A19);
		rc(asmu_pkg::ADDR_A_LO, 32'hFFFFFFFF, 32'h07770246);
		rc(asmu_pkg::ADDR_R, 32'hFFFFFFFF, 32'h9);
		$display("right shift test done");
	endtask
	task t_shift_left_multi;
		xfer(1'b1, asmu_pkg::ADDR_MODE, 32'hFF);
		xfer(1'b1, asmu_pkg::ADDR_Y1, 32'hAAAA);
		xfer(1'b1, asmu_pkg::ADDR_X0, 32'h0014);
		run(32'h039);
		rc(asmu_pkg::ADDR_A_HI, 32'hFFFFFFFF, 32'hF);
		rc(asmu_pkg::ADDR_A_LO, 32'hFFFFFFFF, 32'hAAA00000);
		rc(asmu_pkg::ADDR_CCR, 32'h0C, 32'h08);
		xfer(1'b1, asmu_pkg::ADDR_Y1, 32'h8001);
		xfer(1'b1, asmu_pkg::ADDR_Y0, 32'h0003);
		run(32'h109);
		rc(asmu_pkg::ADDR_X0, 32'hFFFFFFFF, 32'h0008);
		rc(asmu_pkg::ADDR_CCR, 32'h0C, 32'h00);
		run(32'h309);
		chk(st & 32'h3, 32'h2);
		$display("multi shift test done");
	endtask
	task t_and_immediate_mask;
		int fld[5] = '{5, 3, 7, 16, 17};
		int wd[5] = '{5, 67, 7, 32, 17};
		xfer(1'b1, asmu_pkg::ADDR_X0, 32'hC3FF);
		xfer(1'b1, asmu_pkg::ADDR_OPERAND, 32'h5555);
		run(32'h01);
		chk(st & 32'h31, 32'h21);
		rc(asmu_pkg::ADDR_X0, 32'hFFFFFFFF, 32'h4155);
		rc(asmu_pkg::ADDR_CCR, 32'h1, 32'h0);
		xfer(1'b1, asmu_pkg::ADDR_X0, 32'hFFFF);
		run(32'h01);
		rc(asmu_pkg::ADDR_CCR, 32'h1, 32'h1);
		xfer(1'b1, asmu_pkg::ADDR_R, 32'h0);
		xfer(1'b1, asmu_pkg::ADDR_SP, 32'h30);
		for (int i = 0; i < 5; i++)
		begin
			xfer(1'b1, ma(wd[i]), 32'hC3FF);
			xfer(1'b1, asmu_pkg::ADDR_OPERAND, {fld[i][15:0], 16'h5555});
			run(32'(i + 2));
			chk(st & 32'h31, (i == 4) ? 32'h31 : 32'h21);
			rc(ma(wd[i]), 32'hFFFFFFFF, 32'h4155);
		end
		run(32'h71);
		chk(st & 32'h3, 32'h2);
		rc(asmu_pkg::ADDR_X0, 32'hFFFFFFFF, 32'h5555);
		$display("mask test done");
	endtask
	initial
	begin
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		t_regs();
		t_and_immediate_mask();
		t_asl();
		t_asr();
		t_shift_left_multi();
		test_done();
	end
endmodule
